// ---- inc/pslk_pkg.sv ----
// Shared constants and types for the power state link keeper.
// Assumes a single 100 MHz clock and an active-low asynchronous reset.
package pslk_pkg;

  // Device power states, fully powered first.
  typedef enum logic [1:0] {
    PSLK_D0 = 2'h0,
    PSLK_D1 = 2'h1,
    PSLK_D2 = 2'h2,
    PSLK_D3 = 2'h3
  } pslk_pstate_type;

  // Transmit behaviour codes driven toward the line driver.
  localparam logic [1:0] TX_OFF   = 2'h0;  // Nothing driven on the transmit pair.
  localparam logic [1:0] TX_IDLE  = 2'h1;  // Continuous idle stream only.
  localparam logic [1:0] TX_FRAME = 2'h2;  // Normal frame traffic.

  // Value of the generation strap after reset: zero means the earlier generation.
  localparam logic       GEN_LATE_RESET = 1'b0;

  // Length of the auto-negotiation restart pulse, in ns and in cycles.
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         AN_PULSE_NS    = 20;
  localparam logic [3:0] AN_PULSE_CYC   = 4'((AN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// ---- core/pslk_keeper.sv ----
// Link keeper: decides per power state whether the link stays up and how it behaves.
// Assumes power state, event enable and power flags arrive asynchronously from pins.
`timescale 1ns/1ps

// Notes on behaviour
// - Four power states, D0 through D3.
// - D0 always keeps the link active.
// - D3 keeps link only with events and power.
// - D3 drops link without events or power.
// - Low power 10BASE-T: receive only, transmit nothing.
// - Low power 100BASE-TX: idle stream, no frames.
// - Link loss in D1 restarts auto-negotiation.
// - D3 link loss: later generation deep power down.
module pslk_keeper (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Power management inputs from outside the clock domain.
  input  wire logic [1:0] pwr_state,
  input  wire logic       pme_en,
  input  wire logic       pwr_good,
  input  wire logic       gen_late,
  // Link status from the physical layer, also asynchronous.
  input  wire logic       link_up,
  input  wire logic       speed_100,
  // Link control outputs.
  output logic            link_keep,
  output logic [1:0]      tx_diff_pair_mode,
  output logic            rx_diff_pair_en,
  output logic            an_restart,
  output logic            deep_pd
);

  // Three-stage synchronisers; the change counts when stages two and three agree.
  logic [1:0] st_s1_r, st_s2_r, st_s3_r, st_r;
  logic [4:0] f_s1_r, f_s2_r, f_s3_r, f_r;   // pme, power, link, speed, generation.
  logic       gen_late_r;                      // Generation strap caught after release.
  logic       link_up_d_r;                     // Previous filtered link state.
  logic [3:0] an_cnt_r;                        // Restart pulse counter.
  logic       keep_nxt;                        // Combinational keep decision.
  logic       low_pwr;                         // Any power state outside D0.
  logic       link_fall;                       // Filtered link loss event.

  // Synchronises every asynchronous input through three flops.
  // Stage one is read by stage two alone, so a metastable value goes no further.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_s1_r <= 2'h0;
      st_s2_r <= 2'h0;
      st_s3_r <= 2'h0;
      f_s1_r  <= 5'h00;
      f_s2_r  <= 5'h00;
      f_s3_r  <= 5'h00;
    end else begin
      st_s1_r <= pwr_state;
      st_s2_r <= st_s1_r;
      st_s3_r <= st_s2_r;
      f_s1_r  <= {gen_late, speed_100, link_up, pwr_good, pme_en};
      f_s2_r  <= f_s1_r;
      f_s3_r  <= f_s2_r;
    end
  end

  // Accepts a new value only once the second and third stages agree.
  // A level that flickers between stages two and three leaves the held value alone.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= 2'h0;
      f_r  <= 5'h00;
    end else begin
      if (st_s2_r == st_s3_r) begin
        st_r <= st_s3_r;
      end
      for (int i = 0; i < 5; i++) begin
        if (f_s2_r[i] == f_s3_r[i]) begin
          f_r[i] <= f_s3_r[i];
        end
      end
    end
  end

  // Generation strap registered from the filtered level every cycle after reset release.
  // A strap that changes in mid-run takes effect at the next link loss.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gen_late_r <= pslk_pkg::GEN_LATE_RESET;
    end else begin
      gen_late_r <= f_r[4];
    end
  end

  // Decides whether the link is kept in the current power state.
  // D1 and D2 keep the link too, as low power states.
  always_comb begin
    case (pslk_pkg::pslk_pstate_type'(st_r))
      pslk_pkg::PSLK_D0: keep_nxt = 1'b1;
      pslk_pkg::PSLK_D1: keep_nxt = 1'b1;
      pslk_pkg::PSLK_D2: keep_nxt = 1'b1;
      default:           keep_nxt = f_r[0] & f_r[1] & ~deep_pd;
    endcase
  end

  // Low power: any state other than D0, whether the link is kept or not.
  // four state decode
  assign low_pwr   = (st_r != 2'(pslk_pkg::PSLK_D0));
  // A falling edge of the filtered link level marks a loss.
  assign link_fall = link_up_d_r & ~f_r[2];

  // Registers the keep decision and the wire behaviour.
  // Receive stays on whenever the link is kept, at either rate.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link_keep         <= 1'b0;
      tx_diff_pair_mode <= pslk_pkg::TX_OFF;
      rx_diff_pair_en   <= 1'b0;
    end else begin
      link_keep       <= keep_nxt;
      rx_diff_pair_en <= keep_nxt;
      if (!keep_nxt) begin
        tx_diff_pair_mode <= pslk_pkg::TX_OFF;
      end else if (!low_pwr) begin
        tx_diff_pair_mode <= pslk_pkg::TX_FRAME;
      end else if (f_r[3]) begin
        tx_diff_pair_mode <= pslk_pkg::TX_IDLE;
      end else begin
        tx_diff_pair_mode <= pslk_pkg::TX_OFF;
      end
    end
  end

  // Tracks the link for loss detection.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link_up_d_r <= 1'b0;
    end else begin
      link_up_d_r <= f_r[2];
    end
  end

  // Handles link loss: renegotiate, or deep power down in D3 on the later generation.
  // The deep power down flag is sticky until the state leaves D3; a set wins.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      an_cnt_r   <= 4'h0;
      an_restart <= 1'b0;
      deep_pd    <= 1'b0;
    end else begin
      if (link_fall && keep_nxt && st_r == 2'(pslk_pkg::PSLK_D3) && gen_late_r) begin
        deep_pd <= 1'b1;
      end else if (st_r != 2'(pslk_pkg::PSLK_D3)) begin
        deep_pd <= 1'b0;
      end
      if (link_fall && keep_nxt && !(st_r == 2'(pslk_pkg::PSLK_D3) && gen_late_r)) begin
        an_cnt_r <= pslk_pkg::AN_PULSE_CYC;
      end else if (an_cnt_r != 4'h0) begin
        an_cnt_r <= an_cnt_r - 4'h1;
      end
      an_restart <= (an_cnt_r != 4'h0);
    end
  end

  // Assertions guarding the behaviour.
  // State gating checks.
  d0_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r == 2'h0) |=> link_keep)
    else $error("Link not kept in D0.");
  d3_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r == 2'h3 && f_r[0] && f_r[1] && !deep_pd) |=> link_keep)
    else $error("Link dropped in D3 with events and power.");
  d3_drop_a: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r == 2'h3 && !(f_r[0] && f_r[1])) |=> !link_keep)
    else $error("Link kept in D3 without events or power.");
  // Wire behaviour checks.
  tx_ten_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    (keep_nxt && st_r != 2'h0 && !f_r[3]) |=> (tx_diff_pair_mode == 2'h0 && rx_diff_pair_en))
    else $error("10BASE-T low power link transmitted.");
  tx_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
    (keep_nxt && st_r != 2'h0 && f_r[3]) |=> (tx_diff_pair_mode == 2'h1 && rx_diff_pair_en))
    else $error("100BASE-TX low power link not idle.");
  // Link loss checks, then D0 frame and D0 to D2 keep checks.
  sequence d1_loss_s;
    st_r == 2'h1 && link_fall;
  endsequence
  d1_reneg_a: assert property (@(posedge clk) disable iff (!rst_b)
    d1_loss_s |=> ##1 an_restart[*2])
    else $error("No renegotiation after D1 link loss.");
  deep_pd_a: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r == 2'h3 && link_fall && keep_nxt && gen_late_r) |=> (deep_pd ##1 !link_keep))
    else $error("Later generation did not enter deep power down.");
  d0_frames_a: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r == 2'h0) |=> (tx_diff_pair_mode == 2'h2))
    else $error("Frames not resumed in D0.");
  state_range_a: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r != 2'h3) |=> link_keep)
    else $error("Link dropped in D0 to D2.");

  // Further checks, built on a named loss sequence where they take several steps.
  sequence d3_loss_s;
    st_r == 2'h3 && link_fall && keep_nxt;
  endsequence
  d3_early_reneg_a: assert property (@(posedge clk) disable iff (!rst_b)
    (d3_loss_s ##0 !gen_late_r) |=> ##1 an_restart[*2])
    else $error("Earlier generation did not renegotiate after D3 link loss.");
  drop_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!keep_nxt) |=> (tx_diff_pair_mode == 2'h0 && !rx_diff_pair_en))
    else $error("Dropped link still active on the pairs.");
  low_no_frame_a: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r != 2'h0) |=> (tx_diff_pair_mode != 2'h2))
    else $error("Frames sent in a low power state.");
  d0_deep_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r == 2'h0) |=> !deep_pd)
    else $error("Deep power down held in D0.");
  d0_rx_a: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r == 2'h0) |=> rx_diff_pair_en)
    else $error("Receive off in D0.");

endmodule

// ---- verification/pslk_link_partner.sv ----
// Remote link partner: reports the link and the rate that it sees on the pair.
// Assumes the bench drives its cable and speed controls at the falling edge.
`timescale 1ns/1ps
module pslk_link_partner (
  // Controls from the bench.
  input  wire logic cable_ok,
  input  wire logic spd_sel,
  // Status toward the keeper.
  output logic      link_up,
  output logic      speed_100
);
  // The link is up only while a partner sits on the far end of the cable.
  assign link_up   = cable_ok;
  // The rate follows what the two ends negotiated.
  assign speed_100 = spd_sel;
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the power state link keeper.
// Assumes a 100 MHz clock and inputs that settle within eight cycles.
`timescale 1ns/1ps
module tb;
  logic       clk, rst_b, pme_en, pwr_good, gen_late, cable_ok, spd_sel;  // Bench drives.
  logic [1:0] pwr_state;                                   // Requested power state.
  wire logic  link_up, speed_100, link_keep, rx_en, an_restart, deep_pd;  // Observed.
  wire logic [1:0] tx_mode;                                // Transmit pair behaviour.
  int         err_count, total_checks, n;                  // Counters.
  pslk_link_partner u_lp (.cable_ok(cable_ok), .spd_sel(spd_sel), .link_up(link_up),
    .speed_100(speed_100));
  pslk_keeper u_dut (.clk(clk), .rst_b(rst_b), .pwr_state(pwr_state), .pme_en(pme_en),
    .pwr_good(pwr_good), .gen_late(gen_late), .link_up(link_up), .speed_100(speed_100),
    .link_keep(link_keep), .tx_diff_pair_mode(tx_mode), .rx_diff_pair_en(rx_en),
    .an_restart(an_restart), .deep_pd(deep_pd));
  // The clock toggles every half period.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compares one result and reports a difference at once.
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Sets the power inputs, then waits past the input filter.
  task automatic set_in(input logic [1:0] s, input logic p, input logic g, input logic sp);
    pwr_state = s;
    pme_en = p;
    pwr_good = g;
    spd_sel = sp;
    repeat (8) @(negedge clk);
  endtask
  // Checks the three link outputs together.
  task automatic chk_link(input logic k, input logic [1:0] m);
    chk("link_keep", 4'(k), 4'(link_keep));
    chk("tx_mode", 4'(m), 4'(tx_mode));
    chk("rx_en", 4'(k), 4'(rx_en));
  endtask
  // Pulls the cable and counts cycles with the renegotiation pulse high.
  task automatic pull_cable;
    cable_ok = 1'b0;
    n = 0;
    repeat (12) begin
      @(negedge clk);
      if (an_restart === 1'b1) n++;
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // A hang counts as a mismatch and ends the run.
  initial begin
    #20000;
    err_count++;
    report_and_stop();
  end
  // Full power: the link stays up with normal frames.
  task automatic test_full_power;
    set_in(2'h0, 1'b0, 1'b0, 1'b1);
    chk_link(1'b1, pslk_pkg::TX_FRAME);
    $display("full power test done");
  endtask
  // Sleep gate: D3 keeps the link only with events and power, idle or receive only.
  task automatic test_sleep_gate;
    for (int i = 0; i < 4; i++) begin
      set_in(2'h3, i[1], i[0], 1'b1);
      chk_link(i == 3, (i == 3) ? pslk_pkg::TX_IDLE : pslk_pkg::TX_OFF);
    end
    set_in(2'h3, 1'b1, 1'b1, 1'b0);
    chk_link(1'b1, pslk_pkg::TX_OFF);
    $display("sleep gate test done");
  endtask
  // Doze loss: a loss in D1 and in D2 restarts negotiation.
  task automatic test_doze_loss;
    for (int s = 1; s < 3; s++) begin
      set_in(s[1:0], 1'b1, 1'b1, 1'b0);
      chk_link(1'b1, pslk_pkg::TX_OFF);
      pull_cable();
      chk("an_restart", 4'h2, 4'(n));
      cable_ok = 1'b1;
    end
    $display("doze loss test done");
  endtask
  // Sleep loss: renegotiate or deep power down by generation, then back to D0.
  task automatic test_sleep_loss;
    for (int g = 0; g < 2; g++) begin
      gen_late = g[0];
      set_in(2'h3, 1'b1, 1'b1, 1'b1);
      pull_cable();
      chk("an_restart", g ? 4'h0 : 4'h2, 4'(n));
      chk("deep_pd", 4'(g), 4'(deep_pd));
      if (g) chk_link(1'b0, pslk_pkg::TX_OFF);
      cable_ok = 1'b1;
      set_in(2'h0, 1'b1, 1'b1, 1'b1);
      chk("deep_pd", 4'h0, 4'(deep_pd));
      chk_link(1'b1, pslk_pkg::TX_FRAME);
    end
    $display("sleep loss test done");
  endtask
  // Main sequence: reset, then each scenario in turn.
  initial begin
    {pme_en, pwr_good, gen_late, spd_sel, pwr_state} = '0;
    cable_ok = 1'b1;
    rst_b = 1'b0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    test_full_power();
    test_sleep_gate();
    test_doze_loss();
    test_sleep_loss();
    report_and_stop();
  end
endmodule
